// [rtl/phy_mgmt_regs_defs.vh]
// Purpose: constants for the next-page, master/slave, indirect access and transceiver control registers
// Assumes: register byte address is four times the register index
// Notes: definitions only
`ifndef PHY_MGMT_REGS_DEFS_VH
`define PHY_MGMT_REGS_DEFS_VH

// register indices
`define IDX_NEXT_PAGE_TRANSMIT 6'h07
`define IDX_NEXT_PAGE_RECEIVED 6'h08
`define IDX_MASTER_SLAVE_STATUS 6'h0A
`define IDX_INDIRECT_ACCESS_CONTROL 6'h0D
`define IDX_INDIRECT_ADDRESS_DATA 6'h0E
`define IDX_TRANSCEIVER_CONTROL 6'h10
`define IDX_SOFT_RESET 6'h1F

// reset values
`define RST_NEXT_PAGE_TRANSMIT 16'h0001
`define RST_NEXT_PAGE_RECEIVED 16'h0000
`define RST_TRANSCEIVER_CONTROL 16'h0062
`define RST_INDIRECT_ADDRESS_DATA 16'h0000

// writable masks
`define MASK_NEXT_PAGE_TRANSMIT 16'hB7FF
`define MASK_TRANSCEIVER_CONTROL 16'h007F

// field positions
`define BIT_MORE_PAGES 15
`define BIT_PAGE_TYPE_SELECT 13
`define BIT_SECOND_ACK 12
`define BIT_TOGGLE 11
`define BIT_MS_FAULT 15
`define BIT_MS_MASTER 14
`define BIT_LOCAL_RX_OK 13
`define BIT_REMOTE_RX_OK 12
`define BIT_GIG_FULL_ADV 11
`define BIT_PARTNER_GIG_HALF 10
`define FUNC_HI 15
`define FUNC_LO 14
`define DEV_HI 4
`define DEV_LO 0
`define XOVER_HI 6
`define XOVER_LO 5
`define BIT_CARRIER_ON_TX 3
`define BIT_COLLISION_TEST 2
`define BIT_POLARITY_REV 1
`define BIT_JABBER_DISABLE 0
`define BIT_SOFT_RESET_GO 0

// indirect access functions
`define FUNC_ADDRESS 2'h0
`define FUNC_DATA_NO_INC 2'h1
`define FUNC_DATA_INC_RW 2'h2
`define FUNC_DATA_INC_WR 2'h3

// selectable extended devices
`define DEV_MMD1 5'h01
`define DEV_MMD3 5'h03
`define DEV_MMD7 5'h07
`define MMD_WORDS 16

// crossover modes
`define XOVER_STRAIGHT 2'h0
`define XOVER_CROSSED 2'h1
`define XOVER_AUTO 2'h3

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define IDLE_COUNT_MAX 8'hFF

`endif

// [rtl/phy_mgmt_regs.v]
// Purpose: management register slice: next pages, master/slave status, indirect device access, transceiver control
// Assumes: AXI4-Lite slave, 40 MHz clk_sys, link-side inputs synchronous to clk_sys
// Notes: transceiver control settings are staged and applied by the soft reset register
//
// The AXI4-Lite slave port was left to the implementer.
`include "phy_mgmt_regs_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module phy_mgmt_regs (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire page_rx_valid,
  input wire [15:0] page_rx_word,
  input wire page_exchanged,
  input wire ms_fault_event,
  input wire ms_resolved_master,
  input wire local_rx_ok,
  input wire remote_rx_ok,
  input wire gig_full_adv,
  input wire partner_gig_half,
  input wire idle_error,
  input wire link_speed_10,
  input wire link_full_duplex,
  output reg [15:0] next_page_transmit,
  output reg [1:0] crossover_mode,
  output reg carrier_on_transmit,
  output reg collision_test_enable,
  output reg polarity_reversal_enable,
  output reg polarity_force_normal,
  output reg jabber_detect_disable
);

  reg [7:0] aw_addr;
  reg aw_full;
  reg [15:0] w_data;
  reg [1:0] w_strb;
  reg w_full;
  reg [7:0] ar_addr;
  reg rd_pend;
  reg [15:0] next_page_received;
  reg ms_fault;
  reg ms_master;
  reg ms_local_ok;
  reg ms_remote_ok;
  reg ms_gig_full;
  reg ms_gig_half;
  reg [7:0] idle_count;
  reg [1:0] access_function;
  reg [4:0] target_device_select;
  reg [15:0] tcr_pending;
  reg [15:0] tcr_active;
  reg [15:0] mmd_addr [0:2];
  reg [15:0] mmd_mem [0:3*`MMD_WORDS-1];
  reg [15:0] next_rdata;
  reg next_rerr;
  integer i;

  wire wr_go = aw_full && w_full && !s_axi_bvalid;
  wire rd_go = rd_pend && !wr_go && !s_axi_rvalid;
  wire [5:0] wr_idx = aw_addr[7:2];
  wire [5:0] rd_idx = ar_addr[7:2];

  // maps the device field to a slot; 3 means no such device
  function [1:0] dev_slot;
    input [4:0] dev;
    begin
      case (dev)
        `DEV_MMD1: dev_slot = 2'h0;
        `DEV_MMD3: dev_slot = 2'h1;
        `DEV_MMD7: dev_slot = 2'h2;
        default: dev_slot = 2'h3;
      endcase
    end
  endfunction

  function [5:0] mem_index;
    input [1:0] slot;
    input [15:0] addr;
    begin
      mem_index = {slot, addr[3:0]};
    end
  endfunction

  // whether an indirect data access moves the selected device address on
  function post_inc;
    input [1:0] fn;
    input is_write;
    begin
      case (fn)
        `FUNC_DATA_INC_RW: post_inc = 1'b1;
        `FUNC_DATA_INC_WR: post_inc = is_write;
        default: post_inc = 1'b0;
      endcase
    end
  endfunction

  // address step; wraps at the top of the 16-bit space
  function [15:0] step_addr;
    input [15:0] addr;
    begin
      step_addr = addr + 16'h0001;
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] strb;
    begin
      merge16 = {strb[1] ? new_val[15:8] : old_val[15:8], strb[0] ? new_val[7:0] : old_val[7:0]};
    end
  endfunction

  function is_mapped;
    input [5:0] idx;
    begin
      case (idx)
        `IDX_NEXT_PAGE_TRANSMIT, `IDX_NEXT_PAGE_RECEIVED, `IDX_MASTER_SLAVE_STATUS,
        `IDX_INDIRECT_ACCESS_CONTROL, `IDX_INDIRECT_ADDRESS_DATA, `IDX_TRANSCEIVER_CONTROL,
        `IDX_SOFT_RESET: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  wire [1:0] cur_slot = dev_slot(target_device_select);
  wire dev_ok = (cur_slot != 2'h3);
  wire [15:0] cur_addr = dev_ok ? mmd_addr[cur_slot] : 16'h0000;
  wire [15:0] cur_data = dev_ok ? mmd_mem[mem_index(cur_slot, cur_addr)] : 16'h0000;
  wire [15:0] wr_merged_npt = merge16(next_page_transmit, w_data, w_strb);
  wire [15:0] wr_merged_tcr = merge16(tcr_pending, w_data, w_strb);
  wire [15:0] wr_merged_iad = merge16((access_function == `FUNC_ADDRESS) ? cur_addr : cur_data, w_data, w_strb);
  wire [15:0] wr_merged_iac = merge16(16'h0000, w_data, w_strb);
  wire status_read = rd_go && (rd_idx == `IDX_MASTER_SLAVE_STATUS);

  // read data, taken from state before this cycle's side effects
  always @*
  begin
    next_rdata = 16'h0000;
    next_rerr = 1'b0;
    case (rd_idx)
      `IDX_NEXT_PAGE_TRANSMIT: next_rdata = next_page_transmit;
      `IDX_NEXT_PAGE_RECEIVED: next_rdata = next_page_received;
      `IDX_MASTER_SLAVE_STATUS:
        next_rdata = {ms_fault, ms_master, ms_local_ok, ms_remote_ok, ms_gig_full, ms_gig_half, 2'h0, idle_count};
      `IDX_INDIRECT_ACCESS_CONTROL: next_rdata = 16'h0000;
      `IDX_INDIRECT_ADDRESS_DATA:
        next_rdata = (access_function == `FUNC_ADDRESS) ? cur_addr : cur_data;
      `IDX_TRANSCEIVER_CONTROL: next_rdata = tcr_pending;
      `IDX_SOFT_RESET: next_rdata = 16'h0000;
      default: next_rerr = 1'b1;
    endcase
  end

  // bus handshakes
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_addr <= 8'h00;
      aw_full <= 1'b0;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
      w_full <= 1'b0;
      ar_addr <= 8'h00;
      rd_pend <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata[15:0];
        w_strb <= s_axi_wstrb[1:0];
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        ar_addr <= s_axi_araddr;
        rd_pend <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (rd_go)
      begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, next_rdata};
        s_axi_rresp <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // register state and side effects
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      next_page_transmit <= `RST_NEXT_PAGE_TRANSMIT;
      next_page_received <= `RST_NEXT_PAGE_RECEIVED;
      ms_fault <= 1'b0;
      ms_master <= 1'b0;
      ms_local_ok <= 1'b0;
      ms_remote_ok <= 1'b0;
      ms_gig_full <= 1'b0;
      ms_gig_half <= 1'b0;
      idle_count <= 8'h00;
      access_function <= `FUNC_ADDRESS;
      target_device_select <= 5'h00;
      tcr_pending <= `RST_TRANSCEIVER_CONTROL;
      tcr_active <= `RST_TRANSCEIVER_CONTROL;
      for (i = 0; i < 3; i = i + 1)
        mmd_addr[i] <= `RST_INDIRECT_ADDRESS_DATA;
      for (i = 0; i < 3 * `MMD_WORDS; i = i + 1)
        mmd_mem[i] <= 16'h0000;
    end
    else
    begin
      ms_master <= ms_resolved_master;
      ms_local_ok <= local_rx_ok;
      ms_remote_ok <= remote_rx_ok;
      ms_gig_full <= gig_full_adv;
      ms_gig_half <= partner_gig_half;
      // received page: more-pages, type, second_acknowledge and code kept as sent; toggle stored inverted
      if (page_rx_valid)
        next_page_received <= {page_rx_word[`BIT_MORE_PAGES], 1'b0, page_rx_word[13:12],
          ~page_rx_word[`BIT_TOGGLE], page_rx_word[10:0]};
      // fault flag: a new event wins over the clear by read
      if (ms_fault_event)
        ms_fault <= 1'b1;
      else if (status_read)
        ms_fault <= 1'b0;
      // idle errors since last read; an error in the read cycle starts the new count
      if (status_read)
        idle_count <= idle_error ? 8'h01 : 8'h00;
      else if (idle_error && idle_count != `IDLE_COUNT_MAX)
        idle_count <= idle_count + 8'h01;
      // toggle bit follows the exchange of the local page
      if (page_exchanged)
        next_page_transmit[`BIT_TOGGLE] <= ~next_page_transmit[`BIT_TOGGLE];
      if (wr_go)
      begin
        case (wr_idx)
          `IDX_NEXT_PAGE_TRANSMIT:
          begin
            next_page_transmit[15:12] <= {wr_merged_npt[15], 1'b0, wr_merged_npt[13:12]};
            next_page_transmit[10:0] <= wr_merged_npt[10:0];
          end
          `IDX_INDIRECT_ACCESS_CONTROL:
          begin
            access_function <= wr_merged_iac[`FUNC_HI:`FUNC_LO];
            target_device_select <= wr_merged_iac[`DEV_HI:`DEV_LO];
          end
          `IDX_INDIRECT_ADDRESS_DATA:
            if (dev_ok)
            begin
              if (access_function == `FUNC_ADDRESS)
                mmd_addr[cur_slot] <= wr_merged_iad;
              else
              begin
                mmd_mem[mem_index(cur_slot, cur_addr)] <= wr_merged_iad;
                if (post_inc(access_function, 1'b1))
                  mmd_addr[cur_slot] <= step_addr(cur_addr);
              end
            end
          `IDX_TRANSCEIVER_CONTROL:
            tcr_pending <= wr_merged_tcr & `MASK_TRANSCEIVER_CONTROL;
          `IDX_SOFT_RESET:
            if (wr_merged_iac[`BIT_SOFT_RESET_GO])
              tcr_active <= tcr_pending;
          default:
            tcr_active <= tcr_active;
        endcase
      end
      else if (rd_go && rd_idx == `IDX_INDIRECT_ADDRESS_DATA && dev_ok
        && post_inc(access_function, 1'b0))
        mmd_addr[cur_slot] <= step_addr(cur_addr);
    end
  end

  // transceiver outputs driven from the applied settings
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      crossover_mode <= `XOVER_AUTO;
      carrier_on_transmit <= 1'b0;
      collision_test_enable <= 1'b0;
      polarity_reversal_enable <= 1'b1;
      polarity_force_normal <= 1'b0;
      jabber_detect_disable <= 1'b0;
    end
    else
    begin
      crossover_mode <= tcr_active[`XOVER_HI:`XOVER_LO];
      carrier_on_transmit <= tcr_active[`BIT_CARRIER_ON_TX]
        && (!link_speed_10 || !link_full_duplex);
      collision_test_enable <= tcr_active[`BIT_COLLISION_TEST] && !link_full_duplex;
      polarity_reversal_enable <= tcr_active[`BIT_POLARITY_REV];
      polarity_force_normal <= !tcr_active[`BIT_POLARITY_REV] && link_speed_10;
      jabber_detect_disable <= tcr_active[`BIT_JABBER_DISABLE];
    end
  end

endmodule // phy_mgmt_regs

`default_nettype wire

// [dv/phy_mgmt_regs_properties.sv]
// Purpose: port assertions for phy_mgmt_regs
// Assumes: one clock domain, rst async active high
// Notes: bound after endmodule
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_regs_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic page_exchanged,
  input wire logic ms_resolved_master,
  input wire logic local_rx_ok,
  input wire logic remote_rx_ok,
  input wire logic link_speed_10,
  input wire logic link_full_duplex,
  input wire logic [15:0] next_page_transmit,
  input wire logic [1:0] crossover_mode,
  input wire logic carrier_on_transmit,
  input wire logic collision_test_enable,
  input wire logic polarity_reversal_enable,
  input wire logic polarity_force_normal,
  input wire logic jabber_detect_disable
);
  logic [5:0] rd_idx;
  wire [2:0] health = {ms_resolved_master, local_rx_ok, remote_rx_ok};
  wire [3:0] applied = {crossover_mode, polarity_reversal_enable, jabber_detect_disable};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // register index of the outstanding read
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rd_idx <= 6'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rd_idx <= s_axi_araddr[7:2];
  end
  AST_TOGGLE_FLIP: assert property (page_exchanged |=>
    next_page_transmit[11] != $past(next_page_transmit[11])) else $error("toggle did not flip");
  AST_TOGGLE_CAUSE: assert property ($changed(next_page_transmit[11]) |->
    $past(page_exchanged)) else $error("toggle moved alone");
  AST_TX_RSVD: assert property (next_page_transmit[14] == 1'b0) else $error("bit 14 set");
  AST_SQE_HALF: assert property (collision_test_enable |->
    !$past(link_full_duplex)) else $error("collision test in full duplex");
  AST_CRS_MODE: assert property (carrier_on_transmit |->
    !($past(link_speed_10) && $past(link_full_duplex))) else $error("carrier on transmit in 10 full");
  AST_POL_FORCE: assert property (polarity_force_normal |->
    !polarity_reversal_enable && $past(link_speed_10)) else $error("polarity forced wrongly");
  AST_APPLY_ON_WRITE: assert property ($changed(applied) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3)) else $error("setting moved alone");
  AST_MS_HEALTH: assert property ($rose(s_axi_rvalid) && rd_idx == 6'h0A |->
    s_axi_rdata[14:12] == $past(health, 2)) else $error("status bits wrong");
endmodule // phy_mgmt_regs_properties
bind phy_mgmt_regs phy_mgmt_regs_properties chk (.*);
`default_nettype wire

// [dv/mgmt_host.sv]
// Purpose: station management host on the register bus
// Assumes: one write or one read at a time
// Notes: tasks are called from the bench
`timescale 1ns/100ps
`default_nettype none
module mgmt_host (
  input wire logic clk_sys,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h3;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // released lines do not keep the last value
    s_axi_wdata <= ~s_axi_wdata;
    s_axi_awaddr <= ~a;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[15:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    s_axi_araddr <= ~a;
  endtask
endmodule // mgmt_host
`default_nettype wire

// [dv/test_phy_nextpage_mmd_ctrl_regs.sv]
// Purpose: self-checking bench for phy_mgmt_regs
// Assumes: 40 MHz clk_sys, host model drives the register bus
// Notes: expectations come from an integer model of the registers
`timescale 1ns/100ps
`default_nettype none
module test_phy_nextpage_mmd_ctrl_regs;
  logic clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, f, crossover_mode;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, page_rx_valid, page_exchanged, tg;
  logic ms_fault_event, ms_resolved_master, local_rx_ok, remote_rx_ok, gig_full_adv, partner_gig_half;
  logic idle_error, link_speed_10, link_full_duplex, carrier_on_transmit, collision_test_enable;
  logic polarity_reversal_enable, polarity_force_normal, jabber_detect_disable;
  logic [15:0] page_rx_word, next_page_transmit, w, q;
  logic [6:0] v, cur;
  logic [4:0] lv;
  logic [4:0] devs [4] = '{5'h01, 5'h03, 5'h07, 5'h02};
  logic [15:0] ma [4] = '{default: 16'h0000};
  logic [15:0] md [4][16] = '{default: 16'h0000};
  int n_errors = 0, n_tests = 0, i, k, n;
  wire [6:0] outs = {crossover_mode, carrier_on_transmit, collision_test_enable, polarity_reversal_enable,
    polarity_force_normal, jabber_detect_disable};
  phy_mgmt_regs uut (.*);
  mgmt_host host (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    n_tests++;
    if (seen !== expv)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic wchk(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] rr;
    host.wr(a, d, rr);
    chk({14'h0, rr}, 16'h0000);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] expv);
    logic [15:0] d;
    logic [1:0] rr;
    host.rd(a, d, rr);
    chk(d, expv);
    chk({14'h0, rr}, 16'h0000);
  endtask
  function automatic logic [6:0] expo(input logic [6:0] a);
    return {a[6:5], a[3] & (!link_speed_10 | !link_full_duplex), a[2] & !link_full_duplex, a[1],
      !a[1] & link_speed_10, a[0]};
  endfunction
  task automatic cmp_out(input logic [6:0] a);
    repeat (3) @(posedge clk_sys);
    chk({9'h0, outs}, {9'h0, expo(a)});
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #(25 * 20000);
    n_errors++;
    close_out();
  end
  initial
  begin
    rst = 1'b1;
    tg = 1'b0;
    {page_rx_valid, page_exchanged, ms_fault_event, ms_resolved_master, local_rx_ok, remote_rx_ok} = '0;
    {gig_full_adv, partner_gig_half, idle_error, link_speed_10, link_full_duplex, page_rx_word} = '0;
    void'($urandom(32'h1492));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(8'h1C, 16'h0001);
    rchk(8'h20, 16'h0000);
    rchk(8'h40, 16'h0062);
    rchk(8'h34, 16'h0000);
    rchk(8'h28, 16'h0000);
    cur = 7'h62;
    cmp_out(cur);
    for (i = 0; i < 6; i++)
    begin
      w = (i == 0) ? 16'hFFFF : 16'($urandom);
      wchk(8'h1C, w);
      @(posedge clk_sys);
      page_exchanged <= 1'b1;
      @(posedge clk_sys);
      page_exchanged <= 1'b0;
      tg = ~tg;
      rchk(8'h1C, (w & 16'hB7FF) | {4'h0, tg, 11'h000});
      chk(next_page_transmit, (w & 16'hB7FF) | {4'h0, tg, 11'h000});
      @(posedge clk_sys);
      page_rx_word <= w;
      page_rx_valid <= 1'b1;
      @(posedge clk_sys);
      page_rx_valid <= 1'b0;
      page_rx_word <= ~w;
      wchk(8'h20, 16'hFFFF);
      rchk(8'h20, {w[15], 1'b0, w[13:12], ~w[11], w[10:0]});
    end
    for (i = 0; i < 2; i++)
    begin
      lv = 5'($urandom);
      n = i ? 300 : 1 + $urandom % 20;
      @(posedge clk_sys);
      {ms_resolved_master, local_rx_ok, remote_rx_ok, gig_full_adv, partner_gig_half} <= lv;
      ms_fault_event <= 1'b1;
      idle_error <= 1'b1;
      repeat (n) @(posedge clk_sys);
      ms_fault_event <= 1'b0;
      idle_error <= 1'b0;
      rchk(8'h28, {1'b1, lv, 2'b00, (n > 255) ? 8'hFF : 8'(n)});
      rchk(8'h28, {1'b0, lv, 10'h000});
    end
    for (i = 0; i < 48; i++)
    begin
      k = $urandom % 4;
      f = 2'($urandom);
      w = 16'($urandom);
      wchk(8'h34, {f, 9'h000, devs[k]});
      if (i % 2)
      begin
        wchk(8'h38, w);
        if (k < 3 && f == 2'h0)
          ma[k] = w;
        else if (k < 3)
          md[k][ma[k][3:0]] = w;
        if (k < 3 && f[1])
          ma[k] = ma[k] + 16'h0001;
      end
      else
      begin
        rchk(8'h38, (k == 3) ? 16'h0000 : (f == 2'h0) ? ma[k] : md[k][ma[k][3:0]]);
        if (k < 3 && f == 2'h2)
          ma[k] = ma[k] + 16'h0001;
      end
    end
    for (i = 0; i < 8; i++)
    begin
      v = {i[1:0], 5'($urandom)};
      wchk(8'h40, {9'h000, v});
      rchk(8'h40, {9'h000, v});
      cmp_out(cur);
      wchk(8'h7C, 16'h0001);
      cur = v;
      for (k = 0; k < 4; k++)
      begin
        @(posedge clk_sys);
        {link_speed_10, link_full_duplex} <= k[1:0];
        cmp_out(cur);
      end
    end
    host.wr(8'h14, 16'hFFFF, r);
    chk({14'h0, r}, 16'h0002);
    host.rd(8'h14, q, r);
    chk(q, 16'h0000);
    chk({14'h0, r}, 16'h0002);
    // second reset in mid-run: next page transmit, indirect address/data, transceiver control and the outputs read back at reset values
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(8'h1C, 16'h0001);
    rchk(8'h38, 16'h0000);
    rchk(8'h40, 16'h0062);
    cmp_out(7'h62);
    close_out();
  end
endmodule // test_phy_nextpage_mmd_ctrl_regs
`default_nettype wire
